// ==== sre_error_report.sv ====
// System error reporting: enable register, error flags, open-drain error pin.
// Assumes config requests and event pulses come from host-clock logic;
// parity pins arrive asynchronously and are synchronised here.
//
// How it works
// - Enable register at 90h, resets 00h
// - Pin driven only with command enable set
// - Out-of-aperture flag rise raises error
// - Unroutable request sets flag, raises error
// - Bit 6 clear: no unroutable report
// - Decode ignores address bits 35 to 32
// - Invalid translation entry sets flag, raises error
// - Target abort raises error when enabled
// - Sampled parity error raises error
// - Multi-bit or memory parity raises error
// - Single-bit ECC error raises error
// - Flags report only on zero-to-one transition, or on a one written to a clear multi-bit flag
// - ECC flags write-one-clear, unlocking row fields
`include "sre_defines.svh"
`timescale 1ns/1ns
module sre_error_report (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire sre_pkg::sre_cfg_req_t cfg_req,
  output sre_pkg::sre_cfg_rsp_t      cfg_rsp,
  input  wire logic                  pci_serr_enable,
  input  wire logic [31:0]           mem_top,
  input  wire logic [31:0]           aper_base,
  input  wire logic [31:0]           aper_size,
  input  wire sre_pkg::sre_gfx_req_t gfx_req,
  input  wire logic                  gfx_out_aper_ev,
  input  wire logic                  bad_xlat_ev,
  input  wire logic                  tabort_pci_ev,
  input  wire logic                  tabort_gfx_ev,
  input  wire logic                  perr_n,
  input  wire logic                  gperr_n,
  input  wire sre_pkg::sre_dram_ev_t dram_ev,
  output logic                       serr_o,
  output logic                       serr_oe
);
  import sre_pkg::*;

  logic [7:0] enable_reg;
  logic [2:0] multi_row_reg;
  logic [2:0] single_row_reg;
  logic [1:0] perr_sync_reg;
  logic [1:0] gperr_sync_reg;
  logic       perr_prev_reg;
  logic       gperr_prev_reg;
  logic       serr_oe_reg;
  logic       ack_reg;
  logic [7:0] rdata_reg;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic [4:0] flag_q;
  logic [4:0] flag_rise;
  logic [4:0] flag_en;

  // Flag order: 0 bad xlat, 1 no target, 2 out of aperture, 3 single, 4 multi
  wire sel_fn     = (cfg_req.func == `SRE_FUNC_NUM);
  wire hit_enable = sel_fn && (cfg_req.addr == `SRE_OFF_ENABLE);
  wire hit_mem    = sel_fn && (cfg_req.addr == `SRE_OFF_MEM_FLAGS);
  wire hit_gfx    = sel_fn && (cfg_req.addr == `SRE_OFF_GFX_FLAGS);
  wire wr_enable  = cfg_req.wr && hit_enable;
  wire wr_mem     = cfg_req.wr && hit_mem;
  wire wr_gfx     = cfg_req.wr && hit_gfx;

  // Only the low 4 GB alias is decoded; upper bits never reach the compare
  wire [31:0] alias_addr  = gfx_req.addr[31:0];
  wire        in_mem      = alias_addr < mem_top;
  wire [32:0] aper_end    = {1'b0, aper_base} + {1'b0, aper_size};
  wire        in_aper     = (alias_addr >= aper_base) && ({1'b0, alias_addr} < aper_end);
  wire        no_target   = gfx_req.valid && gfx_req.enhanced && !in_mem && !in_aper;

  assign flag_set[`SRE_GFX_BAD_XLAT]  = bad_xlat_ev && enable_reg[`SRE_EN_BAD_XLAT];
  assign flag_set[`SRE_GFX_NO_TARGET] = no_target &&
                                        enable_reg[`SRE_EN_NO_TARGET];
  assign flag_set[`SRE_GFX_OUT_APER]  = gfx_out_aper_ev;
  assign flag_set[3]                  = dram_ev.single_ev;
  assign flag_set[4]                  = dram_ev.multi_ev;
  assign flag_clr[2:0] = {3{wr_gfx}} & cfg_req.wdata[2:0];
  assign flag_clr[3]   = wr_mem && cfg_req.wdata[`SRE_MEM_SINGLE_FLAG];
  assign flag_clr[4]   = wr_mem && cfg_req.wdata[`SRE_MEM_MULTI_FLAG];
  assign flag_en = {enable_reg[`SRE_EN_MULTIBIT], enable_reg[`SRE_EN_SINGLEBIT],
                    enable_reg[`SRE_EN_OUT_APER], enable_reg[`SRE_EN_NO_TARGET],
                    enable_reg[`SRE_EN_BAD_XLAT]};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      sre_sticky_flag u_flag (
        .clk      (clk),
        .nrst     (nrst),
        .set      (flag_set[gi]),
        .clr      (flag_clr[gi]),
        .flag_reg (flag_q[gi]),
        .rise     (flag_rise[gi])
      );
    end
  endgenerate

  // Parity pins: two stages, then an assertion edge so a held pin reports once
  wire perr_ev   = perr_sync_reg[1] && !perr_prev_reg;
  wire gperr_ev  = gperr_sync_reg[1] && !gperr_prev_reg;
  // Writing one to a clear multi-bit flag still reports, matching the flag's quirk
  wire multi_w1z = wr_mem && cfg_req.wdata[`SRE_MEM_MULTI_FLAG] && !flag_q[4];

  wire flag_req   = |(flag_rise & flag_en);
  wire abort_req  = (tabort_pci_ev || tabort_gfx_ev) && enable_reg[`SRE_EN_TGT_ABORT];
  wire parity_req = (perr_ev || gperr_ev) && enable_reg[`SRE_EN_PARITY];
  wire multi_req  = multi_w1z && enable_reg[`SRE_EN_MULTIBIT];
  wire serr_req   = flag_req || abort_req || parity_req || multi_req;
  wire serr_next  = serr_req && pci_serr_enable;

  wire [7:0] enable_next = cfg_req.wdata & `SRE_ENABLE_WMASK;
  wire [7:0] mem_view    = {multi_row_reg, flag_q[4], single_row_reg, flag_q[3]};
  wire [7:0] gfx_view    = {5'h00, flag_q[2:0]};
  wire [7:0] rdata_next  = hit_enable ? enable_reg :
                           hit_mem    ? mem_view   :
                           hit_gfx    ? gfx_view   : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) enable_reg <= `SRE_ENABLE_RESET;
    else if (wr_enable) enable_reg <= enable_next;
  end

  // Row fields lock while their flag is set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      multi_row_reg  <= 3'h0;
      single_row_reg <= 3'h0;
    end else begin
      if (flag_rise[4]) multi_row_reg <= dram_ev.multi_row;
      if (flag_rise[3]) single_row_reg <= dram_ev.single_row;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      perr_sync_reg  <= 2'h0;
      gperr_sync_reg <= 2'h0;
      perr_prev_reg  <= 1'b0;
      gperr_prev_reg <= 1'b0;
    end else begin
      perr_sync_reg  <= {perr_sync_reg[0], ~perr_n};
      gperr_sync_reg <= {gperr_sync_reg[0], ~gperr_n};
      perr_prev_reg  <= perr_sync_reg[1];
      gperr_prev_reg <= gperr_sync_reg[1];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) serr_oe_reg <= 1'b0;
    else       serr_oe_reg <= serr_next;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg   <= cfg_req.rd || cfg_req.wr;
      rdata_reg <= cfg_req.rd ? rdata_next : 8'h00;
    end
  end

  // Open drain: level is always low, enable carries the pulse
  assign serr_o        = 1'b0;
  assign serr_oe       = serr_oe_reg;
  assign cfg_rsp.ack   = ack_reg;
  assign cfg_rsp.rdata = rdata_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_ENABLE_WRITE: assert property (wr_enable |=> enable_reg == $past(enable_next))
    else $error("enable register did not take write");
  AST_CMD_GATE: assert property (serr_oe |-> $past(pci_serr_enable))
    else $error("error pin driven without command enable");
  AST_OUT_APER: assert property (
      (flag_rise[2] && enable_reg[7] && pci_serr_enable) |=> serr_oe && flag_q[2])
    else $error("aperture fault not reported");
  AST_NO_TARGET: assert property (
      (no_target && enable_reg[6] && pci_serr_enable && !flag_q[1])
      |=> flag_q[1] && serr_oe)
    else $error("unroutable request not reported");
  AST_NO_TARGET_OFF: assert property (
      (no_target && !enable_reg[6] && !flag_q[1]) |=> !flag_q[1])
    else $error("unroutable request flagged while disabled");
  AST_ALIAS: assert property (
      (gfx_req.valid && gfx_req.addr[31:0] < mem_top) |-> !no_target)
    else $error("high address bits affected decode");
  AST_BAD_XLAT: assert property (
      (bad_xlat_ev && enable_reg[5] && pci_serr_enable && !flag_q[0])
      |=> flag_q[0] && serr_oe)
    else $error("invalid translation entry not reported");
  AST_ABORT: assert property (
      ((tabort_pci_ev || tabort_gfx_ev) && enable_reg[4] && pci_serr_enable) |=> serr_oe)
    else $error("target abort not reported");
  // Two sync stages and the output register: pin low at edge k, pulse seen at k+3
  AST_PARITY: assert property (
      $fell(perr_n) ##0 (enable_reg[3] && pci_serr_enable)[*3] |=> serr_oe)
    else $error("parity error not reported");
  AST_MULTI: assert property (
      (dram_ev.multi_ev && !flag_q[4] && enable_reg[1] && pci_serr_enable)
      |=> serr_oe && flag_q[4])
    else $error("multi-bit error not reported");
  AST_SINGLE: assert property (
      (dram_ev.single_ev && !flag_q[3] && enable_reg[0] && pci_serr_enable)
      |=> serr_oe ##0 flag_q[3])
    else $error("single-bit error not reported");
  // A repeat single-bit event on a set flag is the only request source here
  AST_EDGE_ONLY: assert property (
      (flag_q[3] && flag_set == 5'h08 && !abort_req && !parity_req && !multi_req)
      |=> !serr_oe)
    else $error("error repeated while flag held");
  AST_W1C: assert property (
      (wr_mem && cfg_req.wdata[4] && !dram_ev.multi_ev) |=> !flag_q[4])
    else $error("multi-bit flag not cleared by write of one");
  AST_ROW_LOCK: assert property (
      (flag_q[4] && dram_ev.multi_ev) |=> $stable(multi_row_reg))
    else $error("row field changed while locked");
  AST_RSVD: assert property (!enable_reg[2])
    else $error("reserved enable bit set");
  AST_PULSE: assert property ((serr_oe && !$past(serr_req)) |-> 1'b0)
    else $error("error pin held without new request");
endmodule // sre_error_report

// ==== sre_defines.svh ====
// Offsets, field positions and reset values of the error-reporting enables.
// Included by the package user files; holds definitions only.
`ifndef SRE_DEFINES_SVH
`define SRE_DEFINES_SVH

`define SRE_FUNC_NUM        3'h0
`define SRE_OFF_ENABLE      8'h90
`define SRE_OFF_MEM_FLAGS   8'h91
`define SRE_OFF_GFX_FLAGS   8'h92
`define SRE_ENABLE_RESET    8'h00
`define SRE_ENABLE_WMASK    8'hFB

`define SRE_EN_OUT_APER     7
`define SRE_EN_NO_TARGET    6
`define SRE_EN_BAD_XLAT     5
`define SRE_EN_TGT_ABORT    4
`define SRE_EN_PARITY       3
`define SRE_EN_RESERVED     2
`define SRE_EN_MULTIBIT     1
`define SRE_EN_SINGLEBIT    0

`define SRE_GFX_OUT_APER    2
`define SRE_GFX_NO_TARGET   1
`define SRE_GFX_BAD_XLAT    0
`define SRE_MEM_MULTI_FLAG  4
`define SRE_MEM_SINGLE_FLAG 0

`endif

// ==== sre_pkg.sv ====
// Types shared by the error-reporting enable block.
// Assumes the defines header supplies all numbers.
package sre_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] func;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sre_cfg_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } sre_cfg_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        enhanced;
    logic [35:0] addr;
  } sre_gfx_req_t;

  typedef struct packed {
    logic       multi_ev;
    logic [2:0] multi_row;
    logic       single_ev;
    logic [2:0] single_row;
  } sre_dram_ev_t;

endpackage

// ==== sre_sticky_flag.sv ====
// One status flag: set by hardware, cleared by writing one.
// Assumes set and clear come from logic on clk.
`timescale 1ns/1ns
module sre_sticky_flag (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_reg,
  output logic      rise
);
  logic flag_next;

  // Set beats a clear in the same cycle so no event is lost
  assign flag_next = set | (flag_reg & ~clr);
  assign rise      = set & ~flag_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) flag_reg <= 1'b0;
    else       flag_reg <= flag_next;
  end
endmodule // sre_sticky_flag

// ==== sre_serr_sink.sv ====
// Chipset end of the open-drain system error wire.
// Assumes the block drives the pin only through serr_o and serr_oe.
`timescale 1ns/1ns
module sre_serr_sink (
  input  wire logic serr_o,
  input  wire logic serr_oe,
  output logic      serr_n
);
  // Pull-up holds the wire high whenever the block lets go
  assign serr_n = serr_oe ? serr_o : 1'b1;
endmodule // sre_serr_sink

// ==== tb.sv ====
// Self-checking bench for the error-reporting enable block.
// Assumes the design, its package and the sink model are compiled first.
`timescale 1ns/1ns
module tb;
  import sre_pkg::*;
  logic         clk     = 1'b0;
  logic         nrst    = 1'b0;
  sre_cfg_req_t req     = '0;
  sre_gfx_req_t gfx     = '0;
  logic [5:0]   evs     = 6'h00;
  logic [2:0]   row     = 3'h0;
  logic         pen     = 1'b1;
  logic         perr_n  = 1'b1;
  logic         gperr_n = 1'b1;
  logic [7:0]   rd;
  sre_cfg_rsp_t rsp;
  sre_dram_ev_t dram;
  logic         serr_o;
  logic         serr_oe;
  logic         serr_n;
  int           fail_count = 0;
  int           num_checks = 0;

  always #4 clk = ~clk;
  assign dram = {evs[4], row, evs[5], row};

  sre_error_report uut (.clk(clk), .nrst(nrst), .cfg_req(req), .cfg_rsp(rsp),
    .pci_serr_enable(pen), .mem_top(32'h10000000), .aper_base(32'h80000000),
    .aper_size(32'h10000000), .gfx_req(gfx), .gfx_out_aper_ev(evs[0]),
    .bad_xlat_ev(evs[1]), .tabort_pci_ev(evs[2]), .tabort_gfx_ev(evs[3]),
    .perr_n(perr_n), .gperr_n(gperr_n), .dram_ev(dram), .serr_o(serr_o),
    .serr_oe(serr_oe));
  sre_serr_sink sink (.serr_o(serr_o), .serr_oe(serr_oe), .serr_n(serr_n));

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cfg(logic wr, logic [7:0] addr, logic [7:0] wdata);
    @(posedge clk);
    req <= '{wr:wr, rd:!wr, func:3'h0, addr:addr, wdata:wdata};
    @(posedge clk);
    req <= '0;
    #1 rd = rsp.rdata;
    chk("ack", {7'h00, rsp.ack}, 8'h01);
  endtask

  task automatic see(logic exp);
    #1 chk("serr_n", {7'h00, serr_n}, {7'h00, !exp});
  endtask

  // Event pulse of one cycle; wire low one cycle after, released the next
  task automatic fire(logic [5:0] v, sre_gfx_req_t g, logic exp);
    @(posedge clk);
    evs <= v;
    gfx <= g;
    @(posedge clk);
    evs <= 6'h00;
    gfx <= '0;
    see(exp);
    @(posedge clk);
    see(1'b0);
  endtask

  // Enables off before clearing, else a clear on multi-bit reports
  task automatic clr();
    cfg(1'b1, 8'h90, 8'h00);
    cfg(1'b1, 8'h91, 8'hFF);
    cfg(1'b1, 8'h92, 8'hFF);
  endtask

  task automatic t_regs();
    cfg(1'b0, 8'h90, 8'h00);
    chk("enable reset", rd, 8'h00);
    cfg(1'b1, 8'h90, 8'hFF);
    cfg(1'b0, 8'h90, 8'h00);
    chk("enable rw", rd, 8'hFB);
    cfg(1'b0, 8'h93, 8'h00);
    chk("unmapped", rd, 8'h00);
    clr();
  endtask

  task automatic t_events();
    logic [5:0] evv [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    logic [7:0] env [6] = '{8'h80, 8'h20, 8'h10, 8'h10, 8'h02, 8'h01};
    for (int i = 0; i < 6; i++) begin
      cfg(1'b1, 8'h90, env[i]);
      fire(evv[i], '0, 1'b1);
      clr();
      fire(evv[i], '0, 1'b0);
      clr();
    end
  endtask

  task automatic t_gate();
    cfg(1'b1, 8'h90, 8'hFB);
    pen <= 1'b0;
    fire(6'h0C, '0, 1'b0);
    pen <= 1'b1;
    fire(6'h0C, '0, 1'b1);
    clr();
  endtask

  task automatic t_hold();
    cfg(1'b1, 8'h90, 8'h01);
    row <= 3'h5;
    fire(6'h20, '0, 1'b1);
    row <= 3'h2;
    fire(6'h20, '0, 1'b0);
    cfg(1'b0, 8'h91, 8'h00);
    chk("single row", rd & 8'h0F, 8'h0B);
    cfg(1'b1, 8'h90, 8'h00);
    cfg(1'b1, 8'h91, 8'h01);
    cfg(1'b0, 8'h91, 8'h00);
    chk("single flag", rd & 8'h01, 8'h00);
  endtask

  // Row lock, clear of a set flag, then a one written to a clear flag
  task automatic t_multi();
    cfg(1'b1, 8'h90, 8'h02);
    row <= 3'h3;
    fire(6'h10, '0, 1'b1);
    row <= 3'h6;
    fire(6'h10, '0, 1'b0);
    cfg(1'b0, 8'h91, 8'h00);
    chk("multi row", rd & 8'hF0, 8'h70);
    cfg(1'b1, 8'h91, 8'h10);
    see(1'b0);
    cfg(1'b0, 8'h91, 8'h00);
    chk("multi flag", rd & 8'h10, 8'h00);
    cfg(1'b1, 8'h91, 8'h10);
    see(1'b1);
    @(posedge clk);
    see(1'b0);
    cfg(1'b0, 8'h91, 8'h00);
    chk("multi flag kept", rd & 8'h10, 8'h00);
    clr();
  endtask

  // Mid-run reset must bring the enables back to all off
  task automatic t_reset();
    cfg(1'b1, 8'h90, 8'hFB);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    cfg(1'b0, 8'h90, 8'h00);
    chk("enable after reset", rd, 8'h00);
  endtask

  task automatic t_gfx();
    cfg(1'b1, 8'h90, 8'h40);
    fire(6'h00, '{1'b1, 1'b1, 36'hF20000000}, 1'b1);
    cfg(1'b0, 8'h92, 8'h00);
    chk("gfx flags", rd, 8'h02);
    clr();
    cfg(1'b1, 8'h90, 8'h40);
    fire(6'h00, '{1'b1, 1'b1, 36'hF00001000}, 1'b0);
    cfg(1'b1, 8'h90, 8'h00);
    fire(6'h00, '{1'b1, 1'b1, 36'h020000000}, 1'b0);
    clr();
  endtask

  task automatic t_parity();
    cfg(1'b1, 8'h90, 8'h08);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      if (j == 0) perr_n <= 1'b0;
      else gperr_n <= 1'b0;
      repeat (3) @(posedge clk);
      see(1'b1);
      @(posedge clk);
      see(1'b0);
      repeat (4) @(posedge clk);
      see(1'b0);
      perr_n <= 1'b1;
      gperr_n <= 1'b1;
      repeat (4) @(posedge clk);
    end
    clr();
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_events();
    t_gate();
    t_hold();
    t_multi();
    t_gfx();
    t_parity();
    t_reset();
    give_verdict();
  end
endmodule // tb
